// [shared/mbm_pkg.sv]
/*
 * Constants and types for the request-to-table reference decoder.
 * Assumes a single system clock; the serial framing sits elsewhere.
 */
// Overview of operation
// RQ1: Leading reference digit picks one of four data types; rest is one-based offset.
// RQ2: Function 2 reads discrete, global input, system and key bits regions.
// RQ3: Functions 1, 5, 15 reach output, internal, temporary and global output bits.
// RQ4: Function 4 reads analog input, global analog input and system words.
// RQ5: Functions 3, 6, 16 reach analog outputs, general registers, global analog outputs.
// RQ6: A master using traditional references addresses each region by its start reference.
// RQ7: A master may instead send function code with zero-based offset.
// RQ8: An uncompletable request gets an exception answer instead of a normal one.
// RQ9: Offsets outside every region, or multi-item runs past region end, are refused.
package mbm_pkg;

	// Data type groups that a function code belongs to
	typedef enum logic [1:0]
	{
		GRP_DISC = 2'b00,
		GRP_COIL = 2'b01,
		GRP_INREG = 2'b10,
		GRP_HOLD = 2'b11
	} mbm_grp_t;

	// Function codes
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISC = 8'h02;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INREG = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_REG = 8'h06;
	localparam logic [7:0] FC_WR_COILS = 8'h0F;
	localparam logic [7:0] FC_WR_REGS = 8'h10;

	// Exception codes
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	// Region table: discrete, coil, input register, holding register regions
	localparam int REG_NUM = 16;
	localparam mbm_grp_t REG_GROUP [REG_NUM] = '{
		GRP_DISC, GRP_DISC, GRP_DISC, GRP_DISC,
		GRP_COIL, GRP_COIL, GRP_COIL, GRP_COIL,
		GRP_INREG, GRP_INREG, GRP_INREG,
		GRP_HOLD, GRP_HOLD, GRP_HOLD, GRP_HOLD, GRP_HOLD};
	localparam logic [15:0] REG_START [REG_NUM] = '{
		16'h0000, 16'h0BB8, 16'h0FA0, 16'h1388,
		16'h0000, 16'h0BB8, 16'h1770, 16'h2328,
		16'h0000, 16'h0BB8, 16'h0FA0,
		16'h0000, 16'h0200, 16'h0BB8, 16'h1770, 16'h2710};
	localparam logic [15:0] REG_SIZE [REG_NUM] = '{
		16'h0800, 16'h0100, 16'h0100, 16'h0004,
		16'h0800, 16'h0800, 16'h0800, 16'h0100,
		16'h0200, 16'h0020, 16'h0100,
		16'h0200, 16'h09B8, 16'h0800, 16'h0020, 16'h2000};

endpackage : mbm_pkg

// [rtl/mbm_region_match.sv]
/*
 * One region comparator: whether a start offset lies in the region,
 * and whether the whole run of items fits. Purely combinational.
 */
`timescale 1ns/100ps
module mbm_region_match
	import mbm_pkg::*;
#(
	parameter logic [15:0] START = 16'h0000,
	parameter logic [15:0] SIZE = 16'h0001
)
(
	// Request
	input wire logic [15:0] offset,
	input wire logic [15:0] count,
	// Result
	output logic in_range,
	output logic fits
);
	logic [16:0] lim_w;
	logic [16:0] end_w;

	// Widened by one bit so the top region cannot wrap
	assign lim_w = {1'b0, START} + {1'b0, SIZE};
	assign end_w = {1'b0, offset} + {1'b0, count};
	// RQ9 range limit
	assign in_range = (offset >= START) && ({1'b0, offset} < lim_w);
	assign fits = in_range && (end_w <= lim_w);
endmodule : mbm_region_match

// [rtl/mbm_decoder.sv]
/*
 * Maps a function code plus zero-based offset onto an internal data
 * region, giving region number and item index, or an exception code.
 * Assumes the frame layer presents one request per req_valid pulse
 * and takes the answer one clock later.
 */
`timescale 1ns/100ps
module mbm_decoder
	import mbm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Request from the frame layer
	input wire logic req_valid,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_offset,
	input wire logic [15:0] req_count,
	// Answer
	output logic resp_valid,
	output logic resp_ok,
	output logic [7:0] resp_exc,
	output logic [3:0] resp_region,
	output logic [15:0] resp_index,
	output logic [15:0] resp_count,
	output logic resp_write
);
	logic fc_legal_w;
	logic single_w;
	logic write_w;
	mbm_grp_t grp_w;
	logic [15:0] cnt_w;
	logic [REG_NUM-1:0] in_w;
	logic [REG_NUM-1:0] fit_w;
	logic [REG_NUM-1:0] hit_w;
	logic any_hit_w;
	logic [3:0] sel_w;
	logic sel_fit_w;
	logic [7:0] exc_w;
	logic [15:0] idx_w;
	logic resp_valid_q;
	logic resp_ok_q;
	logic [7:0] resp_exc_q;
	logic [3:0] resp_region_q;
	logic [15:0] resp_index_q;
	logic [15:0] resp_count_q;
	logic resp_write_q;

	// RQ7 function code decode
	assign fc_legal_w = (req_func == FC_RD_COILS) || (req_func == FC_RD_DISC) ||
		(req_func == FC_RD_HOLD) || (req_func == FC_RD_INREG) ||
		(req_func == FC_WR_COIL) || (req_func == FC_WR_REG) ||
		(req_func == FC_WR_COILS) || (req_func == FC_WR_REGS);
	assign single_w = (req_func == FC_WR_COIL) || (req_func == FC_WR_REG);
	assign write_w = single_w || (req_func == FC_WR_COILS) || (req_func == FC_WR_REGS);
	// RQ1 four data types
	assign grp_w = (req_func == FC_RD_DISC) ? GRP_DISC :
		(req_func == FC_RD_INREG) ? GRP_INREG :
		((req_func == FC_RD_HOLD) || (req_func == FC_WR_REG) ||
		(req_func == FC_WR_REGS)) ? GRP_HOLD : GRP_COIL;
	// Single writes carry a value, not a count, so they always span one item
	assign cnt_w = single_w ? 16'h0001 : req_count;

	// One comparator per region
	generate
		for (genvar i = 0; i < REG_NUM; i++)
		begin : g_reg
			mbm_region_match #(.START(REG_START[i]), .SIZE(REG_SIZE[i])) u_match
			(
				.offset(req_offset),
				.count(cnt_w),
				.in_range(in_w[i]),
				.fits(fit_w[i])
			);
			// RQ2 RQ3 RQ4 RQ5 region belongs to the code's group
			assign hit_w[i] = in_w[i] && (REG_GROUP[i] == grp_w);
		end
	endgenerate

	// Regions of one group never overlap, so the hit is at most one-hot
	function automatic logic [3:0] enc(input logic [REG_NUM-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 0; k < REG_NUM; k++)
		begin
			if (v[k])
			begin
				r = 4'(k);
			end
		end
		return r;
	endfunction : enc

	// Region selection and index
	assign any_hit_w = |hit_w;
	assign sel_w = enc(hit_w);
	assign sel_fit_w = fit_w[sel_w];
	assign idx_w = req_offset - REG_START[sel_w];

	// RQ8 exception choice; RQ9 unmapped and overrun give address fault
	assign exc_w = !fc_legal_w ? EXC_FUNC :
		(cnt_w == 16'h0000) ? EXC_VALUE :
		(!any_hit_w || !sel_fit_w) ? EXC_ADDR : EXC_NONE;

	// Answer strobe, one clock after the request
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			resp_valid_q <= 1'b0;
			resp_ok_q <= 1'b0;
			resp_exc_q <= EXC_NONE;
		end
		else
		begin
			resp_valid_q <= req_valid;
			resp_ok_q <= req_valid && (exc_w == EXC_NONE);
			resp_exc_q <= req_valid ? exc_w : EXC_NONE;
		end
	end

	// Answer payload, held until the next request
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			resp_region_q <= 4'h0;
			resp_index_q <= 16'h0000;
			resp_count_q <= 16'h0000;
			resp_write_q <= 1'b0;
		end
		else if (req_valid)
		begin
			resp_region_q <= sel_w;
			resp_index_q <= idx_w;
			resp_count_q <= cnt_w;
			resp_write_q <= write_w;
		end
	end

	assign resp_valid = resp_valid_q;
	assign resp_ok = resp_ok_q;
	assign resp_exc = resp_exc_q;
	assign resp_region = resp_region_q;
	assign resp_index = resp_index_q;
	assign resp_count = resp_count_q;
	assign resp_write = resp_write_q;

	// Checks on the answer
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence req_s(logic [7:0] fc, logic [15:0] off, logic [15:0] cnt);
		req_valid && req_func == fc && req_offset == off && req_count == cnt;
	endsequence

	sequence ok_s(logic [3:0] reg_n, logic [15:0] idx);
		resp_valid && resp_ok && resp_region == reg_n && resp_index == idx;
	endsequence

	sequence addr_exc_s;
		resp_valid && !resp_ok && resp_exc == EXC_ADDR;
	endsequence

	// RQ8 answer always follows
	answer_follows_a : assert property (req_valid |=> resp_valid) // RQ8
		else $error("request without answer");
	// RQ8 no unasked answer
	no_spurious_a : assert property (!req_valid |=> !resp_valid && !resp_ok) // RQ8
		else $error("answer without request");
	// RQ8 bad function refused
	bad_func_a : assert property (req_valid && !fc_legal_w |=> resp_exc == EXC_FUNC) // RQ8
		else $error("bad function not refused");
	// RQ2 global input bits
	global_inputs_a : assert property (req_s(FC_RD_DISC, 16'h0BBA, 16'h0001) |=> // RQ2
		ok_s(4'h1, 16'h0002))
		else $error("global input bits misplaced");
	// RQ2 below key bits
	key_limit_a : assert property (req_s(FC_RD_DISC, 16'h1384, 16'h0005) |=> // RQ2
		addr_exc_s)
		else $error("key bits overrun accepted");
	// RQ3 temporary bit write
	temp_coil_a : assert property (req_valid && req_func == FC_WR_COIL && // RQ3
		req_offset == 16'h1770 |=> ok_s(4'h6, 16'h0000) ##0 resp_write)
		else $error("temporary bit write misplaced");
	// RQ4 gap after globals
	inreg_gap_a : assert property (req_s(FC_RD_INREG, 16'h0BD8, 16'h0001) |=> // RQ4
		addr_exc_s)
		else $error("gap after global analog inputs accepted");
	// RQ5 upper general registers
	hold_top_a : assert property (req_s(FC_RD_HOLD, 16'h2710, 16'h0010) |=> // RQ5
		ok_s(4'hF, 16'h0000) ##0 resp_count == 16'h0010)
		else $error("upper general registers misplaced");
	// RQ5 lower general registers
	gen_low_a : assert property (req_s(FC_WR_REG, 16'h0200, 16'h0000) |=> // RQ5
		ok_s(4'hC, 16'h0000) ##0 resp_count == 16'h0001)
		else $error("lower general register write misplaced");
	// RQ9 run past end
	overrun_a : assert property (req_valid && fc_legal_w && any_hit_w && !sel_fit_w && // RQ9
		cnt_w != 16'h0000 |=> addr_exc_s)
		else $error("run past region end accepted");
	// RQ9 index from start
	index_rel_a : assert property (resp_ok |-> resp_index + REG_START[resp_region] == // RQ9
		$past(req_offset))
		else $error("item index inconsistent");
	// RQ3 single write spans one
	single_count_a : assert property (req_valid && single_w |=> resp_count == 16'h0001) // RQ3
		else $error("single write count not one");
	// RQ3 multiple writes flagged
	multi_write_a : assert property (req_valid && (req_func == FC_WR_COILS || // RQ3
		req_func == FC_WR_REGS) |=> resp_write)
		else $error("multiple write not flagged");
	// RQ2 reads not flagged
	read_flag_a : assert property (req_valid && req_func == FC_RD_DISC |=> !resp_write) // RQ2
		else $error("read flagged as write");
	// RQ8 ok matches code
	ok_excl_a : assert property (resp_valid |-> resp_ok == (resp_exc == EXC_NONE)) // RQ8
		else $error("ok flag disagrees with exception");
	// RQ8 code only with answer
	exc_idle_a : assert property (!resp_valid |-> resp_exc == EXC_NONE) // RQ8
		else $error("exception code outside answer");
	// RQ8 zero count before address check
	zero_count_a : assert property (req_valid && fc_legal_w && !single_w && // RQ8
		req_count == 16'h0000 |=> resp_exc == EXC_VALUE)
		else $error("zero count not refused");
endmodule : mbm_decoder

// [verif/mbm_master_model.sv]
/*
 * Far-side master: turns a traditional reference into offset.
 * Assumes the bench picks the function code and timing.
 */
`timescale 1ns/100ps
module mbm_master_model
(
	// From the bench
	input wire logic go,
	input wire logic [7:0] fc,
	input wire logic [19:0] rf,
	input wire logic [15:0] cnt,
	// To the decoder
	output logic req_valid,
	output logic [7:0] req_func,
	output logic [15:0] req_offset,
	output logic [15:0] req_count
);
	logic [19:0] off;
	assign off = (rf >= 20'h61A81) ? rf - 20'h61A81 : (rf >= 20'h09C41) ? rf - 20'h09C41 :
		(rf >= 20'h07531) ? rf - 20'h07531 : (rf >= 20'h02711) ? rf - 20'h02711 : rf - 20'h00001;
	// explicit code; idle lines toggle so stale values never pass
	assign req_valid = go;
	assign req_func = go ? fc : ~fc;
	assign req_offset = go ? off[15:0] : ~off[15:0];
	assign req_count = go ? cnt : ~cnt;
endmodule : mbm_master_model

// [verif/modbus_reference_map_tb_top.sv]
/*
 * Table-driven bench for the reference decoder.
 * Assumes the answer lands on the taking edge, checked at the next falling edge.
 */
`timescale 1ns/100ps
module modbus_reference_map_tb_top;
	import mbm_pkg::*;
	typedef struct {logic [7:0] fc; logic [19:0] rf; logic [15:0] cnt;
		logic [7:0] exc; logic [3:0] rg; logic [15:0] ix;} mbm_row_t;
	logic clk = 1'b0, reset = 1'b1, go = 1'b0;
	logic [7:0] fc = 8'h00;
	logic [19:0] rf = 20'h00001;
	logic [15:0] cnt = 16'h0001;
	logic req_valid, resp_valid, resp_ok, resp_write;
	logic [7:0] req_func, resp_exc;
	logic [15:0] req_offset, req_count, resp_index, resp_count;
	logic [3:0] resp_region;
	int n_fail = 0, n_tests = 0;
	mbm_row_t rows [25] = '{
		'{8'h02, 20'h02711, 16'h0001, 8'h00, 4'h0, 16'h0000},
		'{8'h02, 20'h033C8, 16'h0001, 8'h00, 4'h1, 16'h00FF},
		'{8'h02, 20'h036B1, 16'h0100, 8'h00, 4'h2, 16'h0000},
		'{8'h02, 20'h03A9C, 16'h0002, 8'h02, 4'h0, 16'h0000},
		'{8'h01, 20'h00001, 16'h0800, 8'h00, 4'h4, 16'h0000},
		'{8'h05, 20'h00BB9, 16'h0000, 8'h00, 4'h5, 16'h0000},
		'{8'h0F, 20'h01F70, 16'h0001, 8'h00, 4'h6, 16'h07FF},
		'{8'h01, 20'h02329, 16'h0001, 8'h00, 4'h7, 16'h0000},
		'{8'h04, 20'h07730, 16'h0001, 8'h00, 4'h8, 16'h01FF},
		'{8'h04, 20'h080E9, 16'h0021, 8'h02, 4'h0, 16'h0000},
		'{8'h04, 20'h084D1, 16'h0001, 8'h00, 4'hA, 16'h0000},
		'{8'h03, 20'h09C41, 16'h0001, 8'h00, 4'hB, 16'h0000},
		'{8'h06, 20'h09E41, 16'h0000, 8'h00, 4'hC, 16'h0000},
		'{8'h10, 20'h0A7F9, 16'h0010, 8'h00, 4'hD, 16'h0000},
		'{8'h03, 20'h0B3D0, 16'h0001, 8'h00, 4'hE, 16'h001F},
		'{8'h10, 20'h64191, 16'h2000, 8'h00, 4'hF, 16'h0000},
		'{8'h03, 20'h0BB80, 16'h0001, 8'h02, 4'h0, 16'h0000},
		'{8'h07, 20'h09C41, 16'h0001, 8'h01, 4'h0, 16'h0000},
		'{8'h03, 20'h09C41, 16'h0000, 8'h03, 4'h0, 16'h0000},
		'{8'h02, 20'h02F11, 16'h0001, 8'h02, 4'h0, 16'h0000},
		'{8'h02, 20'h032CB, 16'h0001, 8'h00, 4'h1, 16'h0002},
		'{8'h02, 20'h03A95, 16'h0005, 8'h02, 4'h0, 16'h0000},
		'{8'h05, 20'h01771, 16'h0003, 8'h00, 4'h6, 16'h0000},
		'{8'h04, 20'h08109, 16'h0001, 8'h02, 4'h0, 16'h0000},
		'{8'h03, 20'h64191, 16'h0010, 8'h00, 4'hF, 16'h0000}};
	// Free-running system clock
	always #25 clk = ~clk;
	mbm_master_model mbm_master_model_inst (.go(go), .fc(fc), .rf(rf), .cnt(cnt),
		.req_valid(req_valid), .req_func(req_func), .req_offset(req_offset),
		.req_count(req_count));
	mbm_decoder mbm_decoder_inst (.clk(clk), .reset(reset), .req_valid(req_valid),
		.req_func(req_func), .req_offset(req_offset), .req_count(req_count),
		.resp_valid(resp_valid), .resp_ok(resp_ok), .resp_exc(resp_exc),
		.resp_region(resp_region), .resp_index(resp_index), .resp_count(resp_count),
		.resp_write(resp_write));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Present one row at the next falling edge; judge checks its answer one clock later
	task automatic ask(input int i);
		@(negedge clk);
		go = 1'b1;
		fc = rows[i].fc;
		rf = rows[i].rf;
		cnt = rows[i].cnt;
	endtask : ask
	task automatic judge(input int i);
		chk(resp_valid, 1'b1);
		chk(resp_exc, rows[i].exc);
		chk(resp_ok, rows[i].exc === 8'h00);
		if (rows[i].exc === 8'h00)
		begin
			chk(resp_region, rows[i].rg);
			chk(resp_index, rows[i].ix);
			chk(resp_count, (rows[i].fc inside {8'h05, 8'h06}) ? 16'h0001 : rows[i].cnt);
			chk(resp_write, rows[i].fc inside {8'h05, 8'h06, 8'h0F, 8'h10});
		end
	endtask : judge
	task automatic close_out();
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	// Watchdog: a hang counts as a mismatch
	initial
	begin
		#200000;
		n_fail++;
		close_out();
	end
	initial
	begin
		@(negedge clk);
		chk({resp_valid, resp_region}, 16'h0000);
		@(negedge clk);
		reset = 1'b0;
		foreach (rows[i])
		begin
			ask(i);
			@(negedge clk);
			go = 1'b0;
			judge(i);
		end
		// Back to back: second request rides while first answer shows
		ask(15);
		ask(4);
		judge(15);
		@(negedge clk);
		go = 1'b0;
		judge(4);
		@(negedge clk);
		chk(resp_valid, 1'b0);
		chk(resp_region, 4'h4);
		// Reset in mid-run clears the held answer
		reset = 1'b1;
		@(negedge clk);
		chk({resp_valid, resp_region}, 16'h0000);
		reset = 1'b0;
		ask(1);
		@(negedge clk);
		go = 1'b0;
		judge(1);
		close_out();
	end
endmodule : modbus_reference_map_tb_top
